// ===== rtl/p4fs_pkg.sv
// Constants for the port 4 pin function select block.
// Assumes a 32-bit APB slave port and one system clock.
package p4fs_pkg;
  localparam int unsigned PIN_COUNT      = 8;
  localparam int unsigned CODE_WIDTH     = 3;
  localparam int unsigned FUNC_COUNT     = 8;
  // Register map.
  localparam logic [11:0] SELECT_OFFSET  = 12'h010;
  localparam logic [31:0] SELECT_RESET   = 32'h0000_00c0;
  localparam logic [31:0] SELECT_WMASK   = 32'h00ff_ffff;
  localparam int unsigned BASE_LSB       = 0;
  localparam int unsigned ALT_LSB        = 8;
  localparam int unsigned EXT_LSB        = 16;
  // Function codes, ordered extension, alternate, base.
  typedef enum logic [2:0] {
    P4FS_GPIO    = 3'h0,
    P4FS_FUNC_1  = 3'h1,
    P4FS_FUNC_2  = 3'h2,
    P4FS_FUNC_3  = 3'h3,
    P4FS_FUNC_4  = 3'h4,
    P4FS_FUNC_5  = 3'h5,
    P4FS_FUNC_6  = 3'h6,
    P4FS_FUNC_7  = 3'h7
  } p4fs_code_t;
  // Pin 7 functions.
  localparam logic [2:0] P7_SWD_DATA                  = 3'h1;
  localparam logic [2:0] P7_SERIAL_PORT1_TRANSMIT     = 3'h2;
  localparam logic [2:0] P7_TWO_WIRE_CH0_DATA         = 3'h3;
  localparam logic [2:0] P7_SPI_CH0_CHIP_SELECT       = 3'h4;
  localparam logic [2:0] P7_ANTENNA_SWITCH_SIX        = 3'h5;
  localparam logic [2:0] P7_KEYSCAN_OUTPUT_ONE        = 3'h6;
  // Pin 6 functions.
  localparam logic [2:0] P6_SWD_CLOCK                 = 3'h1;
  localparam logic [2:0] P6_SERIAL_PORT1_RECEIVE      = 3'h2;
  localparam logic [2:0] P6_TWO_WIRE_CH0_CLOCK        = 3'h3;
  localparam logic [2:0] P6_SPI_CH0_CLOCK             = 3'h4;
  localparam logic [2:0] P6_ANTENNA_SWITCH_FIVE       = 3'h5;
  localparam logic [2:0] P6_KEYSCAN_OUTPUT_ZERO       = 3'h6;
  // Pin 5 functions; codes 6 and 7 are reserved.
  localparam logic [2:0] P5_PULSE_UNIT2_CHANNEL0      = 3'h1;
  localparam logic [2:0] P5_KEYSCAN_OUTPUT_TWENTYTWO  = 3'h2;
  localparam logic [2:0] P5_MODEM_OFFSET_EST_DONE     = 3'h3;
  localparam logic [2:0] P5_USB_OUTPUT_ENABLE_LOW     = 3'h4;
  localparam logic [2:0] P5_SYNTH_DIVIDER_BIT0        = 3'h5;
  localparam logic [2:0] P5_LAST_VALID                = 3'h5;
  localparam logic [2:0] P76_LAST_VALID               = 3'h6;
  localparam logic [2:0] P40_LAST_VALID               = 3'h0;
endpackage

// ===== rtl/p4fs_port4_function_select.sv
// Port 4 pin function multiplexer with its APB select register.
// Assumes pad inputs are asynchronous; peripheral signals share clock.
// Software sees a single read/write word. Its low three bytes are the base,
// alternate and extension planes. The top byte is not stored and reads back
// as zero. A write takes effect at the access edge of the bus transfer, and
// only the byte lanes that pstrb enables change.
//
// Each pin reads its three-bit code from one bit of each plane. Code zero
// hands the pin to the general-purpose port. Any other code that is listed
// for the pin hands it to one peripheral signal. The peripheral buses are
// indexed by function code, so bit c of pin7FnOut is the peripheral that
// code c selects on pin 7.
//
// A code that is not listed for a pin disconnects the pin. The pad is not
// driven, and no consumer sees its level. Pins 4 to 0 map only the GPIO
// code here, so every other code leaves them floating.
//
// Pad outputs are registered one cycle behind the mux, so a new code or a
// new peripheral level reaches the pad one edge after it is seen. Pad
// inputs pass a two-flop synchroniser and then a register per consumer,
// so the consumer sees a pad change three edges later.
//
// The bus slave answers with no wait states. Read data is captured in the
// setup cycle and stands until the next setup cycle. An access to any
// other offset is refused with pslverr and leaves the register alone.
`timescale 1ns/1ps
module p4fs_port4_function_select
  import p4fs_pkg::*;
(
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        srst,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // General-purpose I/O side
  input  wire logic [7:0]  gpioOut,
  input  wire logic [7:0]  gpioOe,
  output logic      [7:0]  gpioIn,
  // Peripheral sides of pins 7, 6, 5, indexed by function code
  input  wire logic [7:0]  pin7FnOut,
  input  wire logic [7:0]  pin7FnOe,
  output logic      [7:0]  pin7FnIn,
  input  wire logic [7:0]  pin6FnOut,
  input  wire logic [7:0]  pin6FnOe,
  output logic      [7:0]  pin6FnIn,
  input  wire logic [7:0]  pin5FnOut,
  input  wire logic [7:0]  pin5FnOe,
  output logic      [7:0]  pin5FnIn,
  // Package pins
  input  wire logic [7:0]  padIn,
  output logic      [7:0]  padOut,
  output logic      [7:0]  padOe,
  // Current code of every pin
  output logic      [23:0] pinCodes
);

  logic [31:0] select_q;
  logic [31:0] readData_q;
  logic [7:0]  padMeta_q;
  logic [7:0]  padSync_q;
  logic [7:0]  padOut_d;
  logic [7:0]  padOe_d;
  logic [7:0]  padOut_q;
  logic [7:0]  padOe_q;
  logic [7:0]  gpioIn_q;
  logic [7:0]  pin7In_q;
  logic [7:0]  pin6In_q;
  logic [7:0]  pin5In_q;
  logic [2:0]  code [PIN_COUNT];
  logic        hit;
  logic        setup;
  logic        access;

  // Builds the code of pin n from the three planes.
  function automatic logic [2:0] pinCode(input logic [31:0] sel,
                                         input int unsigned n);
    pinCode = {sel[EXT_LSB + n], sel[ALT_LSB + n], sel[BASE_LSB + n]};
  endfunction

  // Highest listed code of pin n; anything above is unlisted.
  function automatic logic [2:0] lastValid(input int unsigned n);
    if (n >= 6) begin
      lastValid = P76_LAST_VALID;
    end else if (n == 5) begin
      lastValid = P5_LAST_VALID;
    end else begin
      lastValid = P40_LAST_VALID;
    end
  endfunction

  assign hit    = (paddr == SELECT_OFFSET);
  assign setup  = psel && !penable;
  assign access = psel && penable;

  // Zero-wait slave: read data is captured in the setup cycle.
  // A refused access still completes at once; only pslverr marks it.
  assign pready  = 1'b1;
  assign pslverr = access && !hit;
  assign prdata  = readData_q;

  always_ff @(posedge clock) begin
    if (srst) begin
      select_q <= SELECT_RESET;
    end else if (access && pwrite && hit) begin
      for (int b = 0; b < 4; b++) begin
        if (pstrb[b]) begin
          select_q[b*8 +: 8] <= pwdata[b*8 +: 8] & SELECT_WMASK[b*8 +: 8];
        end
      end
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      readData_q <= 32'h0000_0000;
    end else if (setup) begin
      readData_q <= hit ? (select_q & SELECT_WMASK) : 32'h0000_0000;
    end
  end

  // Two-stage synchroniser for the pads.
  // Only the second stage is read by the routing logic below, so a
  // metastable first stage never fans out to several consumers.
  always_ff @(posedge clock) begin
    if (srst) begin
      padMeta_q <= 8'h00;
      padSync_q <= 8'h00;
    end else begin
      padMeta_q <= padIn;
      padSync_q <= padMeta_q;
    end
  end

  always_comb begin
    for (int n = 0; n < PIN_COUNT; n++) begin
      code[n] = pinCode(select_q, n);
      pinCodes[n*3 +: 3] = code[n];
    end
  end

  // Output side: GPIO, the selected peripheral, or nothing.
  always_comb begin
    padOut_d = 8'h00;
    padOe_d  = 8'h00;
    for (int n = 0; n < PIN_COUNT; n++) begin
      if (code[n] == P4FS_GPIO) begin
        padOut_d[n] = gpioOut[n];
        padOe_d[n]  = gpioOe[n];
      end else if (code[n] > lastValid(n)) begin
        padOut_d[n] = 1'b0;
        padOe_d[n]  = 1'b0;
      end else if (n == 7) begin
        padOut_d[n] = pin7FnOut[code[n]];
        padOe_d[n]  = pin7FnOe[code[n]];
      end else if (n == 6) begin
        padOut_d[n] = pin6FnOut[code[n]];
        padOe_d[n]  = pin6FnOe[code[n]];
      end else if (n == 5) begin
        padOut_d[n] = pin5FnOut[code[n]];
        padOe_d[n]  = pin5FnOe[code[n]];
      end
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      padOut_q <= 8'h00;
      padOe_q  <= 8'h00;
    end else begin
      padOut_q <= padOut_d;
      padOe_q  <= padOe_d;
    end
  end

  assign padOut = padOut_q;
  assign padOe  = padOe_q;

  // Input side: only the selected consumer sees the pad level.
  always_ff @(posedge clock) begin
    if (srst) begin
      gpioIn_q <= 8'h00;
      pin7In_q <= 8'h00;
      pin6In_q <= 8'h00;
      pin5In_q <= 8'h00;
    end else begin
      for (int n = 0; n < PIN_COUNT; n++) begin
        gpioIn_q[n] <= (code[n] == P4FS_GPIO) && padSync_q[n];
      end
      for (int c = 1; c < FUNC_COUNT; c++) begin
        pin7In_q[c] <= (code[7] == c[2:0]) && (c[2:0] <= P76_LAST_VALID)
                       && padSync_q[7];
        pin6In_q[c] <= (code[6] == c[2:0]) && (c[2:0] <= P76_LAST_VALID)
                       && padSync_q[6];
        pin5In_q[c] <= (code[5] == c[2:0]) && (c[2:0] <= P5_LAST_VALID)
                       && padSync_q[5];
      end
    end
  end

  assign gpioIn   = gpioIn_q;
  assign pin7FnIn = pin7In_q;
  assign pin6FnIn = pin6In_q;
  assign pin5FnIn = pin5In_q;

endmodule // p4fs_port4_function_select

// ===== test/p4fs_props.sv
// Checker for the port 4 select block, bound to its top module.
// Assumes the single clock and synchronous reset of that block.
`timescale 1ns/1ps
module p4fs_props (
  input wire logic        clock, srst, psel, penable, pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata, prdata,
  input wire logic [3:0]  pstrb,
  input wire logic        pready, pslverr,
  input wire logic [7:0]  gpioOut, pin7FnOut, padOut, padOe,
  input wire logic [23:0] pinCodes
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);
  wire acc = psel && penable && pready;
  a_unmapped_err: assert property (acc && paddr != 12'h010 |-> pslverr)
    else $error("no error on unmapped access");
  a_reserved_zero: assert property (acc && !pwrite |-> prdata[31:24] == 8'h00)
    else $error("reserved bits read nonzero");
  a_code_order: assert property (acc && pwrite && paddr == 12'h010 && pstrb == 4'hf |=> pinCodes[23:21] == {$past(pwdata[23]), $past(pwdata[15]), $past(pwdata[7])})
    else $error("pin 7 code order wrong");
  a_gpio_route: assert property (!$past(srst) && $past(pinCodes[2:0]) == 3'h0 |-> padOut[0] == $past(gpioOut[0]))
    else $error("pin 0 not on gpio");
  a_pin7_route: assert property (!$past(srst) && $past(pinCodes[23:21]) == 3'h3 |-> padOut[7] == $past(pin7FnOut[3]))
    else $error("pin 7 code 3 misrouted");
  a_pin5_resv: assert property (!$past(srst) && $past(pinCodes[17:15]) > 3'h5 |-> !padOe[5])
    else $error("pin 5 reserved code drives");
  a_pin4_off: assert property (!$past(srst) && $past(pinCodes[14:12]) != 3'h0 |-> !padOe[4])
    else $error("pin 4 unlisted code drives");
  a_reset_value: assert property ($fell(srst) |-> pinCodes == 24'h240000 && prdata == 32'h0)
    else $error("reset codes wrong");
  c_write: cover property (acc && pwrite);
  c_resv: cover property (pinCodes[17:15] == 3'h7);
  c_err: cover property (pslverr);
endmodule // p4fs_props
bind p4fs_port4_function_select p4fs_props p4fs_props_inst (
  .clock(clock), .srst(srst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pstrb(pstrb), .pready(pready), .pslverr(pslverr), .gpioOut(gpioOut),
  .pin7FnOut(pin7FnOut), .padOut(padOut), .padOe(padOe),
  .pinCodes(pinCodes));

// ===== test/p4fs_pads.sv
// Pad model: a pin shows the block's drive while enabled.
// Undriven pins show a level that flips every clock.
`timescale 1ns/1ps
module p4fs_pads (
  input  wire logic       clock,
  input  wire logic [7:0] padOut,
  input  wire logic [7:0] padOe,
  output logic      [7:0] padIn
);
  logic flip = 1'b0;
  always_ff @(posedge clock) flip <= ~flip;
  assign padIn = (padOe & padOut) | (~padOe & {8{flip}});
endmodule // p4fs_pads

// ===== test/testbench.sv
// Bench for the port 4 select block with a pad model on its pins.
// Assumes a zero or more wait state APB slave at offset 0x010.
`timescale 1ns/1ps
module testbench;
  import p4fs_pkg::*;
  logic        clock = 1'b0, srst = 1'b1, psel = 1'b0, penable = 1'b0;
  logic        pwrite = 1'b0, pready, pslverr, er;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [3:0]  pstrb = 4'h0;
  logic [7:0]  gpioOut = 8'hff, gpioOe = 8'hff, fnOut = 8'h00;
  logic [7:0]  gpioIn, p7In, p6In, p5In, padIn, padOut, padOe, e;
  logic [23:0] pinCodes;
  int          miscompares = 0, n_tests = 0;
  always #20 clock = ~clock;
  task automatic results;
    if (miscompares == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, input logic [3:0] s);
    int k;
    k = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
      k++;
    end while (pready !== 1'b1 && k < 50);
    rd = prdata;
    er = pslverr;
    if (k >= 50) begin
      miscompares++;
      results;
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask
  task automatic t_reset;
    apb(1'b0, 12'h010, 32'h0, 4'h0);
    check(rd, 32'h0000_00c0);
    check(32'(pinCodes), 32'h0024_0000);
  endtask
  task automatic t_codes;
    logic [31:0] w;
    for (int c = 0; c < 8; c++) begin
      w = {8'hff, {4{c[2]}}, 4'h0, {4{c[1]}}, 4'h0, {4{c[0]}}, 4'h0};
      fnOut <= 8'h01 << c;
      apb(1'b1, 12'h010, w, 4'hf);
      repeat (6) @(posedge clock);
      e = {c < 7, c < 7, c < 6, c == 0, 4'hf};
      check(32'(padOe), 32'(e));
      check(32'(padOut), 32'(e));
      check(32'(p7In), (c > 0 && c < 7) ? 32'h1 << c : 32'h0);
      check(32'(p6In), (c > 0 && c < 7) ? 32'h1 << c : 32'h0);
      check(32'(p5In), (c > 0 && c < 6) ? 32'h1 << c : 32'h0);
      check(32'(gpioIn), c == 0 ? 32'hff : 32'h0f);
      apb(1'b0, 12'h010, 32'h0, 4'h0);
      check(rd, w & 32'h00ff_ffff);
    end
  endtask
  task automatic t_lanes;
    apb(1'b1, 12'h010, 32'h0, 4'h2);
    apb(1'b0, 12'h010, 32'h0, 4'h0);
    check(rd, 32'h00f0_00f0);
  endtask
  task automatic t_unmapped;
    apb(1'b1, 12'h014, 32'h0, 4'hf);
    check(32'(er), 32'h1);
    apb(1'b0, 12'h010, 32'h0, 4'h0);
    check(rd, 32'h00f0_00f0);
  endtask
  p4fs_port4_function_select p4fs_port4_function_select_inst (
    .clock(clock), .srst(srst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .gpioOut(gpioOut), .gpioOe(gpioOe), .gpioIn(gpioIn),
    .pin7FnOut(fnOut), .pin7FnOe(fnOut), .pin7FnIn(p7In),
    .pin6FnOut(fnOut), .pin6FnOe(fnOut), .pin6FnIn(p6In),
    .pin5FnOut(fnOut), .pin5FnOe(fnOut), .pin5FnIn(p5In),
    .padIn(padIn), .padOut(padOut), .padOe(padOe), .pinCodes(pinCodes));
  p4fs_pads p4fs_pads_inst (
    .clock(clock), .padOut(padOut), .padOe(padOe), .padIn(padIn));
  initial begin
    repeat (4) @(posedge clock);
    srst <= 1'b0;
    @(posedge clock);
    t_reset;
    t_codes;
    t_lanes;
    t_unmapped;
    results;
  end
endmodule // testbench
